//--- emst_consts.vh
// Constants for the external memory strobe timing block.
// Functional notes
// - Setup phase 0-3 clocks from two-bit field.
// - Strobe width is code plus one clocks.
// - Hold phase 0-3 clocks from two-bit field.
// - Timing register 8 bits, 0xAF, resets ones.
// - Strobe width stays between 1 and 16 clocks.
// - Latch high and low 1-4 clocks.
// - Write data set up 1-19 clocks before strobe end.
// - Write data held 0-3 clocks after strobe.
// - Modes 01,10,11 do 16-bit multiplexed moves.
// - Modes 01,11 8-bit moves without bank.
// - Mode 10 8-bit moves drive page bank.
// - Reset selects longest setup, width, hold.
// - Latch width code 00-11 gives 1-4 clocks.
// - Move lasts four plus programmed phase clocks.
// - Mode 00 internal, 01/10 split, 11 external.
`ifndef EMST_CONSTS_VH
`define EMST_CONSTS_VH
`define EMST_TIMING_ADDR 8'h0_0AF
`define EMST_CONFIG_ADDR 8'h0_0AB
`define EMST_PAGE_ADDR 8'h0_0AA
`define EMST_SFR_PAGE 4'h0
`define EMST_TIMING_RESET 8'h0_0FF
`define EMST_CONFIG_RESET 8'h0_003
`define EMST_PAGE_RESET 8'h0_000
`define EMST_SETUP_MSB 7
`define EMST_SETUP_LSB 6
`define EMST_WIDTH_MSB 5
`define EMST_WIDTH_LSB 2
`define EMST_HOLD_MSB 1
`define EMST_HOLD_LSB 0
`define EMST_MODE_MSB 3
`define EMST_MODE_LSB 2
`define EMST_LATCH_MSB 1
`define EMST_LATCH_LSB 0
`define EMST_MODE_INTERNAL 2'h0
`define EMST_MODE_SPLIT 2'h1
`define EMST_MODE_SPLIT_BANK 2'h2
`define EMST_MODE_EXTERNAL 2'h3
`define EMST_FIXED_CYCLES 4'h4
`endif

//--- emst_phase_counter.v
// Down-counter that times one access phase in whole clock periods.
module emst_phase_counter (
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Load and status.
  input wire load,
  input wire [4:0] load_value,
  output wire done,
  output reg [4:0] count
);
  always @(posedge clock)
  begin
    if (!rst_b)
      count <= 5'h0_000;
    else if (load)
      count <= load_value;
    else if (count != 5'h0_000)
      count <= count - 5'h0_001;
  end

  assign done = (count == 5'h0_000);
endmodule // emst_phase_counter

//--- emst_controller.v
// External memory interface sequencer with its timing registers.
`include "emst_consts.vh"
module emst_controller (
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Special function register port.
  input wire [7:0] sfr_addr,
  input wire [3:0] sfr_page,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // Move-external requests from the core.
  input wire req,
  input wire req_write,
  input wire req_wide,
  input wire [15:0] req_addr,
  input wire [7:0] req_wdata,
  output wire busy,
  output reg done,
  output reg [7:0] rd_data,
  // Memory pins.
  output reg [7:0] addr_hi,
  output reg addr_hi_oe,
  output reg [7:0] ad_out,
  output reg ad_oe,
  input wire [7:0] ad_in,
  output reg latch_en,
  output reg rd_strobe_b,
  output reg wr_strobe_b
);
  localparam ST_IDLE = 3'h0;
  localparam ST_FIXED = 3'h1;
  localparam ST_LATCH_HI = 3'h2;
  localparam ST_LATCH_LO = 3'h3;
  localparam ST_SETUP = 3'h4;
  localparam ST_STROBE = 3'h5;
  localparam ST_HOLD = 3'h6;

  reg [7:0] ext_mem_timing_ctrl;
  reg [7:0] ext_mem_config;
  reg [7:0] page_sel;
  reg [2:0] state;
  reg [2:0] next_state;
  reg write_op;
  reg [7:0] wdata;
  reg [7:0] ad_sync1;
  reg [7:0] ad_sync2;
  reg rd_cap1;
  reg rd_cap2;
  reg cnt_load;
  reg [4:0] cnt_value;
  wire cnt_done;
  wire [4:0] cnt_count;
  wire page_hit;
  wire [1:0] addr_setup_sel;
  wire [3:0] strobe_width_sel;
  wire [1:0] addr_hold_sel;
  wire [1:0] iface_mode_sel;
  wire [1:0] latch_pulse_width_sel;
  wire external;

  assign addr_setup_sel = ext_mem_timing_ctrl[`EMST_SETUP_MSB:`EMST_SETUP_LSB];
  assign strobe_width_sel = ext_mem_timing_ctrl[`EMST_WIDTH_MSB:`EMST_WIDTH_LSB];
  assign addr_hold_sel = ext_mem_timing_ctrl[`EMST_HOLD_MSB:`EMST_HOLD_LSB];
  assign iface_mode_sel = ext_mem_config[`EMST_MODE_MSB:`EMST_MODE_LSB];
  assign latch_pulse_width_sel = ext_mem_config[`EMST_LATCH_MSB:`EMST_LATCH_LSB];
  assign page_hit = (sfr_page == `EMST_SFR_PAGE);

  // Mode 00 keeps every move on chip; 8-bit moves in split modes go out only for
  // an upper page. Wide moves always go out when the mode allows it.
  assign external = (iface_mode_sel != `EMST_MODE_INTERNAL) &&
    (req_wide || iface_mode_sel == `EMST_MODE_EXTERNAL || page_sel[4]);
  assign busy = (state != ST_IDLE);

  // Register port.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      ext_mem_timing_ctrl <= `EMST_TIMING_RESET;
      ext_mem_config <= `EMST_CONFIG_RESET;
      page_sel <= `EMST_PAGE_RESET;
    end
    else if (sfr_wr && page_hit)
    begin
      if (sfr_addr == `EMST_TIMING_ADDR)
        ext_mem_timing_ctrl <= sfr_wdata;
      if (sfr_addr == `EMST_CONFIG_ADDR)
        ext_mem_config <= {4'h0, sfr_wdata[3:0]};
      if (sfr_addr == `EMST_PAGE_ADDR)
        page_sel <= {3'h0, sfr_wdata[4:0]};
    end
  end

  always @(posedge clock)
  begin
    if (!rst_b)
      sfr_rdata <= 8'h0_000;
    else if (sfr_rd && page_hit && sfr_addr == `EMST_TIMING_ADDR)
      sfr_rdata <= ext_mem_timing_ctrl;
    else if (sfr_rd && page_hit && sfr_addr == `EMST_CONFIG_ADDR)
      sfr_rdata <= ext_mem_config;
    else if (sfr_rd && page_hit && sfr_addr == `EMST_PAGE_ADDR)
      sfr_rdata <= page_sel;
    else
      sfr_rdata <= 8'h0_000;
  end

  // Read data comes from the pins, so it is synchronised like any input.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      ad_sync1 <= 8'h0_000;
      ad_sync2 <= 8'h0_000;
    end
    else
    begin
      ad_sync1 <= ad_in;
      ad_sync2 <= ad_sync1;
    end
  end

  emst_phase_counter u_phase (
    .clock(clock),
    .rst_b(rst_b),
    .load(cnt_load),
    .load_value(cnt_value),
    .done(cnt_done),
    .count(cnt_count)
  );

  // A counter value of N gives N+1 clocks in a phase; zero-length phases are skipped.
  always @*
  begin
    next_state = state;
    cnt_load = 1'b0;
    cnt_value = 5'h0_000;
    case (state)
      ST_IDLE:
        if (req)
        begin
          cnt_load = 1'b1;
          cnt_value = {1'b0, `EMST_FIXED_CYCLES} - 5'h0_002;
          next_state = ST_FIXED;
        end
      ST_FIXED:
        if (cnt_done)
        begin
          cnt_load = 1'b1;
          if (external)
          begin
            cnt_value = {3'h0, latch_pulse_width_sel};
            next_state = ST_LATCH_HI;
          end
          else
            next_state = ST_IDLE;
        end
      ST_LATCH_HI:
        if (cnt_done)
        begin
          cnt_load = 1'b1;
          cnt_value = {3'h0, latch_pulse_width_sel};
          next_state = ST_LATCH_LO;
        end
      ST_LATCH_LO:
        if (cnt_done)
        begin
          cnt_load = 1'b1;
          if (addr_setup_sel != 2'h0)
          begin
            cnt_value = {3'h0, addr_setup_sel} - 5'h0_001;
            next_state = ST_SETUP;
          end
          else
          begin
            cnt_value = {1'b0, strobe_width_sel};
            next_state = ST_STROBE;
          end
        end
      ST_SETUP:
        if (cnt_done)
        begin
          cnt_load = 1'b1;
          cnt_value = {1'b0, strobe_width_sel};
          next_state = ST_STROBE;
        end
      ST_STROBE:
        if (cnt_done)
        begin
          cnt_load = 1'b1;
          if (addr_hold_sel != 2'h0)
          begin
            cnt_value = {3'h0, addr_hold_sel} - 5'h0_001;
            next_state = ST_HOLD;
          end
          else
            next_state = ST_IDLE;
        end
      ST_HOLD:
        if (cnt_done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Pin outputs are registered from next_state, so each pin lines up with the phase.
  always @(posedge clock)
  begin
    if (!rst_b)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // The core may change its request lines once the move has been taken, except req_wide, which still decides external when ST_FIXED ends.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      write_op <= 1'b0;
      wdata <= 8'h0_000;
    end
    else if (state == ST_IDLE && req)
    begin
      write_op <= req_write;
      wdata <= req_wdata;
    end
  end

  // Bit 4 of the page register only sends 8-bit moves off chip, so the bank on the
  // upper lines is the low four bits. Internal moves never drive the upper lines.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      addr_hi <= 8'h0_000;
      addr_hi_oe <= 1'b0;
    end
    else if (state == ST_IDLE && req)
    begin
      addr_hi <= req_wide ? req_addr[15:8] : {4'h0, page_sel[3:0]};
      addr_hi_oe <= external &&
        (req_wide || iface_mode_sel == `EMST_MODE_SPLIT_BANK);
    end
    else if (next_state == ST_IDLE)
      addr_hi_oe <= 1'b0;
  end

  // Multiplexed low byte: address through both latch phases, then write data.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      ad_out <= 8'h0_000;
      ad_oe <= 1'b0;
    end
    else
    begin
      if (state == ST_IDLE && req)
        ad_out <= req_addr[7:0];
      else if (write_op && (next_state == ST_SETUP || next_state == ST_STROBE))
        ad_out <= wdata;
      ad_oe <= (next_state == ST_LATCH_HI) || (next_state == ST_LATCH_LO) ||
        (write_op && (next_state == ST_SETUP || next_state == ST_STROBE ||
        next_state == ST_HOLD));
    end
  end

  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      latch_en <= 1'b0;
      rd_strobe_b <= 1'b1;
      wr_strobe_b <= 1'b1;
    end
    else
    begin
      latch_en <= (next_state == ST_LATCH_HI);
      rd_strobe_b <= !(next_state == ST_STROBE && !write_op);
      wr_strobe_b <= !(next_state == ST_STROBE && write_op);
    end
  end

  // The pin synchroniser costs two clocks, so the byte that stood at the last strobe
  // clock reaches rd_data two clocks after the strobe ends. With a hold phase shorter
  // than two clocks that is after done, and the core has to allow for it.
  always @(posedge clock)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
      rd_cap1 <= 1'b0;
      rd_cap2 <= 1'b0;
      rd_data <= 8'h0_000;
    end
    else
    begin
      done <= busy && next_state == ST_IDLE;
      rd_cap1 <= state == ST_STROBE && cnt_done && !write_op;
      rd_cap2 <= rd_cap1;
      if (rd_cap2)
        rd_data <= ad_sync2;
    end
  end
endmodule // emst_controller

//--- emst_properties.sv
// Port checks for the external memory strobe timing controller.
module emst_checker (
  // Clock and reset.
  input wire clock,
  input wire rst_b,
  // Register port.
  input wire [7:0] sfr_addr,
  input wire [3:0] sfr_page,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // Memory pins.
  input wire ad_oe,
  input wire latch_en,
  input wire rd_strobe_b,
  input wire wr_strobe_b
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] tc;
  logic [1:0] lw;
  logic [4:0] lo;
  logic [4:0] gap;
  logic [2:0] hi;
  logic lq;
  wire strb = !rd_strobe_b || !wr_strobe_b;
  wire wr0 = sfr_wr && sfr_page == 4'h0;
  // Shadow copies let the checks follow timing that is reprogrammed mid-run.
  always @(posedge clock)
  begin
    lq <= latch_en;
    lo <= strb ? lo + 5'h01 : 5'h00;
    hi <= latch_en ? hi + 3'h1 : 3'h0;
    gap <= (lq && !latch_en) ? 5'h01 : gap + 5'h01;
    if (!rst_b)
      {tc, lw} <= 10'h3ff;
    else if (wr0 && sfr_addr == 8'haf)
      tc <= sfr_wdata;
    else if (wr0 && sfr_addr == 8'hab)
      lw <= sfr_wdata[1:0];
  end
  strobe_width_a: assert property ($rose(!strb) |-> lo == tc[5:2] + 5'h01)
    else $error("bad strobe width");
  latch_width_a: assert property ($fell(latch_en) |-> hi == lw + 3'h1)
    else $error("bad latch width");
  setup_gap_a: assert property ($rose(strb) |-> gap == lw + tc[7:6] + 5'h01)
    else $error("bad setup gap");
  strobe_excl_a: assert property (!(!rd_strobe_b && !wr_strobe_b))
    else $error("both strobes low");
  read_release_a: assert property (!rd_strobe_b |-> !ad_oe)
    else $error("bus driven on read");
  write_data_a: assert property (!wr_strobe_b |-> ad_oe)
    else $error("no write data");
  latch_addr_a: assert property (latch_en |-> ad_oe)
    else $error("no address at latch");
  reg_read_a: assert property (sfr_rd && sfr_page == 4'h0 && sfr_addr == 8'haf |=> sfr_rdata == $past(tc))
    else $error("bad timing readback");
  cover property ($rose(strb) && !wr_strobe_b);
  cover property ($rose(strb) && !rd_strobe_b);
  cover property ($fell(latch_en) && lw == 2'h0);
endmodule // emst_checker
bind emst_controller emst_checker u_chk (.clock, .rst_b, .sfr_addr, .sfr_page, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .ad_oe, .latch_en, .rd_strobe_b, .wr_strobe_b);

//--- emst_mem_model.sv
// Behavioural asynchronous memory on the multiplexed bus.
module emst_mem_model (
  // Clock and speed.
  input wire clock,
  input wire slow,
  // Bus pins.
  input wire [7:0] addr_hi,
  input wire addr_hi_oe,
  input wire [7:0] ad,
  input wire latch_en,
  input wire rd_strobe_b,
  input wire wr_strobe_b,
  // Read drive and bank byte seen.
  output logic [7:0] drive,
  output logic [7:0] seen_hi,
  output logic seen_hi_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  logic [7:0] lo;
  logic [7:0] last = 8'ha5;
  logic [2:0] age = 3'h0;
  wire [15:0] key = {addr_hi_oe ? addr_hi : 8'h00, lo};
  wire ok = !rd_strobe_b && (!slow || age > 3'h2);
  // Off the strobe the bus shows the inverse of the last byte, never a held copy.
  assign drive = ok ? mem[key] : ~last;
  always @(posedge clock)
  begin
    if (latch_en)
      lo <= ad;
    if (!wr_strobe_b)
      mem[key] <= ad;
    if (ok)
      last <= mem[key];
    age <= rd_strobe_b ? 3'h0 : age + {2'h0, age != 3'h7};
    if (!rd_strobe_b || !wr_strobe_b)
      {seen_hi_oe, seen_hi} <= {addr_hi_oe, addr_hi};
  end
endmodule // emst_mem_model

//--- tb_top.sv
// Self-checking bench for the external memory strobe timing controller.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, req = 0, req_write = 0;
  logic req_wide = 0, slow = 0;
  logic [3:0] sfr_page = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, req_wdata = 0, tc = 8'hff, cf;
  logic [15:0] req_addr = 0;
  logic [7:0] sfr_rdata, rd_data, addr_hi, ad_out, drv, seen_hi;
  logic busy, done, addr_hi_oe, ad_oe, latch_en, rd_strobe_b, wr_strobe_b, seen_hi_oe;
  int num_errors = 0;
  int samples_checked = 0;
  wire [7:0] ad = ad_oe ? ad_out : drv;
  always #10 clock = ~clock;
  emst_controller uut (.clock, .rst_b, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .req, .req_write, .req_wide, .req_addr, .req_wdata, .busy, .done, .rd_data,
    .addr_hi, .addr_hi_oe, .ad_out, .ad_oe, .ad_in(ad), .latch_en, .rd_strobe_b, .wr_strobe_b);
  emst_mem_model mem (.clock, .slow, .addr_hi, .addr_hi_oe, .ad, .latch_en, .rd_strobe_b,
    .wr_strobe_b, .drive(drv), .seen_hi, .seen_hi_oe);
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task reg_acc(input logic wr, input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    {sfr_wr, sfr_rd, sfr_page, sfr_addr, sfr_wdata} = {wr, !wr, pg, a, d};
    @(posedge clock);
    #1;
    {sfr_wr, sfr_rd} = 2'b00;
    if (!wr)
      chk("sfr_rdata", {8'h00, d}, {8'h00, sfr_rdata});
  endtask
  task cfg(input logic [7:0] t, input logic [7:0] c);
    reg_acc(1, 4'h0, 8'haf, t);
    reg_acc(1, 4'h0, 8'hab, c);
    reg_acc(0, 4'h0, 8'haf, t);
    {tc, cf} = {t, c};
  endtask
  task move(input logic w, input logic wide, input logic [15:0] a, input logic [7:0] d,
    input logic ext, input logic [8:0] hx);
    int n;
    n = 0;
    @(posedge clock);
    #1;
    {req, req_write, req_wide, req_addr, req_wdata} = {1'b1, w, wide, a, d};
    @(posedge clock);
    #1;
    req = 0;
    chk("busy", 16'h0001, {15'h0000, busy});
    while (done !== 1'b1 && n < 100)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    // The count starts at the edge after the request, so the request clock is added.
    chk("cycles", 16'(ext ? 7 + 2 * cf[1:0] + tc[7:6] + tc[5:2] + tc[1:0] : 4),
      16'(n + 1));
    if (!w)
    begin
      // Read data lands two clocks after the strobe ends, which may follow done.
      repeat (2) @(posedge clock);
      #1;
      chk("rd_data", {8'h00, d}, {8'h00, rd_data});
    end
    if (ext)
      chk("addr_hi", {7'h00, hx}, {7'h00, seen_hi_oe, seen_hi_oe ? seen_hi : 8'h00});
  endtask
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    logic [7:0] d;
    logic [15:0] a;
    logic [7:0] tt [3];
    tt = '{8'hff, 8'h00, 8'h5a};
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1;
    reg_acc(0, 4'h0, 8'haf, 8'hff);
    reg_acc(0, 4'h0, 8'hab, 8'h03);
    reg_acc(0, 4'h0, 8'ha5, 8'h00);
    reg_acc(1, 4'hf, 8'haf, 8'h00);
    reg_acc(0, 4'h0, 8'haf, 8'hff);
    reg_acc(1, 4'h0, 8'haa, 8'h11);
    for (int m = 1; m < 4; m++)
      for (int i = 0; i < 3; i++)
      begin
        cfg(tt[i], {4'h0, 2'(m), tt[i][1:0]});
        a = {8'h10 + 8'(i), 8'h20 + 8'(m)};
        d = 8'(16 * m + i);
        move(1, 1, a, d, 1, {1'b1, a[15:8]});
        move(0, 1, a, d, 1, {1'b1, a[15:8]});
        move(1, 0, a, ~d, 1, m == 2 ? 9'h101 : 9'h000);
        move(0, 0, a, ~d, 1, m == 2 ? 9'h101 : 9'h000);
      end
    slow = 1;
    cfg(8'hff, 8'h0f);
    move(0, 1, a, d, 1, {1'b1, a[15:8]});
    slow = 0;
    cfg(8'h00, 8'h00);
    move(1, 1, a, d, 0, 9'h000);
    reg_acc(1, 4'h0, 8'haa, 8'h01);
    cfg(8'h00, 8'h04);
    move(1, 0, a, d, 0, 9'h000);
    finish_test;
  end
  // The tests need about 1000 cycles, so 20000 leaves a wide margin.
  initial
  begin
    #400000;
    num_errors++;
    finish_test;
  end
endmodule // tb_top
